// *** verilog/baro_seq_pkg.sv ***
//****************************************************************************
// Purpose: shared constants of the measurement-mode sequencer
//****************************************************************************
// Assumes: 100 MHz system clock, AHB-Lite register access
// Notes:   printed register offsets are indexes; byte address is index * 4
package baro_seq_pkg;

    // ************************************************************
    // register indexes and address width
    // ************************************************************
    localparam logic [7:0]  IDX_DATAWR    = 8'h01;
    localparam logic [7:0]  IDX_ADDPTR    = 8'h02;
    localparam logic [7:0]  IDX_OPERATION = 8'h03;
    localparam logic [7:0]  IDX_OPERATION_STATUS_REG  = 8'h04;
    localparam logic [7:0]  IDX_PRESS_HI  = 8'h7f;
    localparam logic [7:0]  IDX_PRESS_LO  = 8'h80;
    localparam logic [7:0]  IDX_TEMP      = 8'h81;
    localparam logic [7:0]  IDX_IND_CFG   = 8'h00;
    localparam int unsigned ADDR_W        = 10;

    // ************************************************************
    // operation codes and configuration values
    // ************************************************************
    localparam logic [7:0]  OP_STANDBY    = 8'h00;
    localparam logic [7:0]  OP_HIRES      = 8'h0a;
    localparam logic [7:0]  OP_TRIGGERED  = 8'h0c;
    localparam logic [7:0]  CFG_RES17     = 8'h05;
    localparam logic [7:0]  CFG_RES15     = 8'h0d;

    // ************************************************************
    // reset values and widths
    // ************************************************************
    localparam logic [7:0]  RST_OPERATION = 8'h00;
    localparam logic [7:0]  RST_CFG       = CFG_RES17;
    localparam logic [7:0]  RST_DATAWR    = 8'h00;
    localparam logic [7:0]  RST_ADDPTR    = 8'h00;
    localparam int unsigned PRESS_W       = 19;
    localparam int unsigned TEMP_W        = 14;
    localparam int unsigned CNT_W         = 32;
    localparam logic [18:0] MASK_RES17    = 19'h7fffc;
    localparam logic [18:0] MASK_RES15    = 19'h7fff0;

    // ************************************************************
    // timing in ms and derived cycle counts
    // ************************************************************
    localparam int unsigned CLK_HZ        = 100_000_000;
    localparam int unsigned CYC_PER_MS    = CLK_HZ / 1000;
    localparam int unsigned T_CONV17_MS   = 500;
    localparam int unsigned T_CONV15_MS   = 140;
    localparam int unsigned T_ULP_PER_MS  = 1000;
    localparam int unsigned T_SWITCH_MS   = 50;
    localparam int unsigned CONV17_CYC    = T_CONV17_MS * CYC_PER_MS;
    localparam int unsigned CONV15_CYC    = T_CONV15_MS * CYC_PER_MS;
    localparam int unsigned ULP_PER_CYC   = T_ULP_PER_MS * CYC_PER_MS;

    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_CONVERT,
        SEQ_REST
    } seq_state_t;

endpackage : baro_seq_pkg

// *** verilog/conv_timer_if.sv ***
//****************************************************************************
// Purpose: start/abort/done link between sequencer and its timer
//****************************************************************************
// Assumes: both ends on clk
// Notes:   load is sampled only with start
`timescale 1ns/10ps
interface conv_timer_if;
    import baro_seq_pkg::*;
    logic             start;
    logic             abort;
    logic [CNT_W-1:0] load;
    logic             done;
    logic             busy;

    modport ctl (output start, output abort, output load,
                 input done, input busy);
    modport tmr (input start, input abort, input load,
                 output done, output busy);
endinterface : conv_timer_if

// *** verilog/conv_timer.sv ***
//****************************************************************************
// Purpose: down-counter timing conversions and rest periods
//****************************************************************************
// Assumes: load of at least one cycle
// Notes:   done pulses one cycle after the count reaches its end
`timescale 1ns/10ps
module conv_timer
    import baro_seq_pkg::*;
(
    // clock, reset, enable
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic ce,
    // control
    conv_timer_if.tmr tm
);
    logic [CNT_W-1:0] cnt_q;
    logic             busy_q;
    logic             done_q;

    assign tm.busy = busy_q;
    assign tm.done = done_q;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            cnt_q  <= '0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end
        else if (ce)
        begin
            done_q <= 1'b0;
            if (tm.abort)
            begin
                busy_q <= 1'b0;
            end
            else if (tm.start)
            begin
                cnt_q  <= tm.load - 1'b1;
                busy_q <= 1'b1;
            end
            else if (busy_q)
            begin
                if (cnt_q == '0)
                begin
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                end
                else
                begin
                    cnt_q <= cnt_q - 1'b1;
                end
            end
        end
    end
endmodule : conv_timer

// *** verilog/trig_edge.sv ***
//****************************************************************************
// Purpose: two-stage synchroniser and rising-edge finder for trigger pin
//****************************************************************************
// Assumes: pin is asynchronous to clk
// Notes:   edge pulse lags the pin by two clk edges
`timescale 1ns/10ps
module trig_edge
(
    // clock, reset, enable
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic ce,
    // pin and event
    input  wire logic pin,
    output logic      rise
);
    logic meta_q;
    logic sync_q;
    logic last_q;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            last_q <= 1'b0;
        end
        else if (ce)
        begin
            meta_q <= pin;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    assign rise = ce & sync_q & ~last_q;
endmodule : trig_edge

// *** verilog/baro_mode_seq.sv ***
//****************************************************************************
// Purpose: measurement-mode sequencer with AHB-Lite register slave
//****************************************************************************
// Assumes: front end delivers raw pressure/temperature words on clk
// Notes:   zero wait state slave, always OKAY
`timescale 1ns/10ps
module baro_mode_seq
    import baro_seq_pkg::*;
#(
    parameter logic [7:0]  OP_HISPEED   = 8'h09,
    parameter logic [7:0]  OP_ULTRALOW  = 8'h0b,
    parameter int unsigned CONV17_CYCLES = CONV17_CYC,
    parameter int unsigned CONV15_CYCLES = CONV15_CYC,
    parameter int unsigned ULP_CYCLES    = ULP_PER_CYC
)
(
    // clock, reset, enable
    input  wire logic                 clk,
    input  wire logic                 sys_rst,
    input  wire logic                 ce,
    // ahb-lite slave
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic                      hreadyout,
    output logic                      hresp,
    output logic [31:0]               hrdata,
    // measurement front end
    input  wire logic [PRESS_W-1:0]   raw_pressure,
    input  wire logic [TEMP_W-1:0]    raw_temperature,
    // pins
    input  wire logic                 trigger_pin,
    output logic                      result_ready_pin
);

    // ************************************************************
    // register state
    // ************************************************************
    logic [7:0]         operation_q;
    logic [7:0]         cfg_q;
    logic [7:0]         datawr_q;
    logic [7:0]         addptr_q;
    logic [PRESS_W-1:0] pressure_q;
    logic [TEMP_W-1:0]  temperature_q;
    logic               ready_q;
    logic [31:0]        rdata_q;
    logic               wr_pend_q;
    logic [7:0]         wr_idx_q;
    seq_state_t         state_q;
    logic               lp_res15_q;

    logic               addr_ok;
    logic [7:0]         addr_idx;
    logic               rd_take;
    logic               wr_commit;
    logic               op_write;
    logic               trig_rise;
    logic               cancel;
    logic               begin_conv;
    logic [CNT_W-1:0]   conv_len;
    logic               idle_kick;
    logic               op_trig_q;

    conv_timer_if tif ();

    // ************************************************************
    // helpers
    // ************************************************************
    // word index of a byte address, valid only when aligned and in range
    function automatic logic [7:0] word_index(input logic [31:0] a);
        word_index = a[9:2];
    endfunction : word_index

    function automatic logic hits(input logic [7:0] idx,
                                  input logic [7:0] reg_idx);
        hits = (idx == reg_idx);
    endfunction : hits

    function automatic logic is_continuous(input logic [7:0] op);
        is_continuous = (op == OP_HIRES) || (op == OP_HISPEED)
                     || (op == OP_ULTRALOW);
    endfunction : is_continuous

    // ************************************************************
    // submodules
    // ************************************************************
    conv_timer u_timer (
        .clk     (clk),
        .sys_rst (sys_rst),
        .ce      (ce),
        .tm      (tif.tmr)
    );

    trig_edge u_trig (
        .clk     (clk),
        .sys_rst (sys_rst),
        .ce      (ce),
        .pin     (trigger_pin),
        .rise    (trig_rise)
    );

    // ************************************************************
    // ahb-lite address phase
    // ************************************************************
    assign addr_idx  = word_index(haddr);
    assign addr_ok   = (haddr[31:ADDR_W] == '0) && (haddr[1:0] == 2'b00);
    assign rd_take   = ce & hsel & htrans[1] & hready & ~hwrite;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = rdata_q;

    // write data arrives a cycle later, so the index is held until then
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            wr_pend_q <= 1'b0;
            wr_idx_q  <= 8'h00;
        end
        else if (ce)
        begin
            wr_pend_q <= hsel & htrans[1] & hready & hwrite & addr_ok;
            wr_idx_q  <= addr_idx;
        end
    end

    assign wr_commit = ce & wr_pend_q;
    assign op_write  = wr_commit & hits(wr_idx_q, IDX_OPERATION);

    // read data captured in address phase so hrdata is a flop output
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            rdata_q <= 32'h0000_0000;
        end
        else if (rd_take)
        begin
            rdata_q <= 32'h0000_0000;
            if (addr_ok)
            begin
                unique case (1'b1)
                    hits(addr_idx, IDX_DATAWR):
                        rdata_q[7:0] <= datawr_q;
                    hits(addr_idx, IDX_ADDPTR):
                        rdata_q[7:0] <= addptr_q;
                    hits(addr_idx, IDX_OPERATION):
                        rdata_q[7:0] <= operation_q;
                    hits(addr_idx, IDX_OPERATION_STATUS_REG):
                        rdata_q[0] <= (state_q != SEQ_IDLE);
                    hits(addr_idx, IDX_PRESS_HI):
                        rdata_q[2:0] <= pressure_q[18:16];
                    hits(addr_idx, IDX_PRESS_LO):
                        rdata_q[15:0] <= pressure_q[15:0];
                    hits(addr_idx, IDX_TEMP):
                        rdata_q[13:0] <= temperature_q;
                    default:
                        rdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ************************************************************
    // configuration registers
    // ************************************************************
    // the indirect configuration register is loaded when the data
    // register is written while the pointer selects it
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            datawr_q <= RST_DATAWR;
            addptr_q <= RST_ADDPTR;
            cfg_q    <= RST_CFG;
        end
        else if (wr_commit)
        begin
            if (hits(wr_idx_q, IDX_DATAWR))
            begin
                datawr_q <= hwdata[7:0];
                if (addptr_q == IDX_IND_CFG)
                begin
                    cfg_q <= hwdata[7:0];
                end
            end
            if (hits(wr_idx_q, IDX_ADDPTR))
            begin
                addptr_q <= hwdata[7:0];
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            operation_q <= RST_OPERATION;
        end
        else if (op_write)
        begin
            operation_q <= hwdata[7:0];
        end
    end

    // ************************************************************
    // sequencer
    // ************************************************************
    // any operation write ends the running job first; a code that is
    // not known simply leaves the block idle, with the trigger pin ignored
    assign cancel = op_write;

    assign begin_conv = ce & (state_q == SEQ_IDLE) & ~op_write
                      & (trig_rise & ((operation_q == OP_STANDBY)
                      | (operation_q == OP_TRIGGERED)));

    // resolution decides conversion length in standby and triggered modes; OP_HIRES, OP_HISPEED and OP_ULTRALOW fix it
    always_comb
    begin
        conv_len = CNT_W'(CONV17_CYCLES);
        if ((operation_q == OP_HISPEED) || (operation_q == OP_ULTRALOW))
        begin
            conv_len = CNT_W'(CONV15_CYCLES);
        end
        else if ((operation_q != OP_HIRES) && ((state_q == SEQ_IDLE)
                 ? (cfg_q == CFG_RES15) : lp_res15_q))
        begin
            conv_len = CNT_W'(CONV15_CYCLES);
        end
    end

    always_comb
    begin
        tif.start = 1'b0;
        tif.abort = cancel;
        tif.load  = conv_len;
        if (ce & ~cancel)
        begin
            unique case (state_q)
                SEQ_IDLE:
                    tif.start = begin_conv | idle_kick;
                SEQ_CONVERT:
                begin
                    if (tif.done && (operation_q == OP_ULTRALOW))
                    begin
                        tif.start = 1'b1;
                        tif.load  = CNT_W'(ULP_CYCLES - CONV15_CYCLES);
                    end
                    else if (tif.done && is_continuous(operation_q))
                    begin
                        tif.start = 1'b1;
                    end
                end
                SEQ_REST:
                    tif.start = tif.done;
            endcase
        end
    end

    // a write of 0x0C is its own trigger once in standby
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            state_q    <= SEQ_IDLE;
            op_trig_q  <= 1'b0;
            lp_res15_q <= 1'b0;
        end
        else if (ce)
        begin
            op_trig_q <= op_write && (hwdata[7:0] == OP_TRIGGERED);
            if (cancel)
            begin
                state_q <= SEQ_IDLE;
            end
            else
            begin
                unique case (state_q)
                    SEQ_IDLE:
                    begin
                        // continuous codes start on the cycle after the write
                        if (is_continuous(operation_q) || op_trig_q
                            || begin_conv)
                        begin
                            state_q    <= SEQ_CONVERT;
                            lp_res15_q <= (cfg_q == CFG_RES15);
                        end
                    end
                    SEQ_CONVERT:
                    begin
                        if (tif.done)
                        begin
                            if (operation_q == OP_ULTRALOW)
                            begin
                                state_q <= SEQ_REST;
                            end
                            else if (!is_continuous(operation_q))
                            begin
                                state_q <= SEQ_IDLE;
                            end
                        end
                    end
                    SEQ_REST:
                    begin
                        if (tif.done)
                        begin
                            state_q <= SEQ_CONVERT;
                        end
                    end
                endcase
            end
        end
    end

    // idle entry into convert starts the timer for continuous and
    // register-triggered cases; pin triggers start it through begin_conv
    assign idle_kick = ce & ~cancel & (state_q == SEQ_IDLE) & ~begin_conv
                     & (is_continuous(operation_q) | op_trig_q);

    // ************************************************************
    // results and ready pin
    // ************************************************************
    // pressure is masked to the conversion resolution; temperature passes unchanged
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            pressure_q    <= '0;
            temperature_q <= '0;
        end
        else if (ce && (state_q == SEQ_CONVERT) && tif.done && !cancel)
        begin
            pressure_q <= raw_pressure & (conv_len == CNT_W'(CONV15_CYCLES)
                          ? MASK_RES15 : MASK_RES17);
            temperature_q <= raw_temperature;
        end
    end

    // a fresh result in the same cycle as the low-word read keeps it set
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            ready_q <= 1'b0;
        end
        else if (ce)
        begin
            if ((state_q == SEQ_CONVERT) && tif.done && !cancel)
            begin
                ready_q <= 1'b1;
            end
            else if (rd_take && addr_ok && hits(addr_idx, IDX_PRESS_LO))
            begin
                ready_q <= 1'b0;
            end
        end
    end

    assign result_ready_pin = ready_q;

endmodule : baro_mode_seq

// *** testbench/baro_seq_checker.sv ***
// Purpose: bus and ready-pin properties of the sequencer
// Assumes: bus idle while ce is low
// Notes:   bound to every instance of baro_mode_seq
`timescale 1ns/10ps
module baro_seq_checker
#(
    parameter int unsigned CONV15_CYCLES = 20
)
(
    // clock, reset and enable
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        ce,
    // bus
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    // pin
    input wire logic        result_ready_pin
);
    logic        tx_q;
    logic        rd_q;
    logic [9:0]  a_q;
    logic [31:0] gap_q;
    wire         tx = hsel & htrans[1] & hready & ce;
    wire         mapped = a_q inside {10'h004, 10'h008, 10'h00c, 10'h010,
                                      10'h1fc, 10'h200, 10'h204};
    always_ff @(posedge clk)
    begin
        tx_q <= tx & !sys_rst;
        rd_q <= tx & !hwrite & !sys_rst;
        a_q  <= haddr[9:0];
    end
    // cycles since the last rise; a second rise needs a whole conversion
    always_ff @(posedge clk)
    begin
        if (sys_rst || $rose(result_ready_pin))
            gap_q <= 32'h0;
        else if (gap_q != 32'hffffffff)
            gap_q <= gap_q + 32'h1;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    chk_zero_wait: assert property (hreadyout)
        else $error("wait state inserted");
    chk_resp_okay: assert property (!hresp)
        else $error("error response");
    chk_ready_reset: assert property ($fell(sys_rst) |-> !result_ready_pin)
        else $error("ready high after reset");
    chk_unmapped_zero: assert property (rd_q && !mapped |-> hrdata == 0)
        else $error("unmapped read not zero");
    chk_temp_width: assert property (rd_q && a_q == 10'h204
        |-> hrdata[31:14] == 0) else $error("temperature too wide");
    chk_press_high: assert property (rd_q && a_q == 10'h1fc
        |-> hrdata[31:3] == 0) else $error("pressure high too wide");
    chk_status_width: assert property (rd_q && a_q == 10'h010
        |-> hrdata[31:1] == 0) else $error("status too wide");
    chk_low_clears: assert property (rd_q && a_q == 10'h200
        |-> ##[0:2] !result_ready_pin) else $error("ready kept");
    chk_ready_holds: assert property (result_ready_pin && !tx && !tx_q
        |=> result_ready_pin) else $error("ready dropped");
    chk_conv_gap: assert property ($rose(result_ready_pin)
        |-> gap_q >= CONV15_CYCLES) else $error("result too soon");
    cov_ready: cover property ($rose(result_ready_pin));
    cov_low_read: cover property (rd_q && a_q == 10'h200);
    cov_unmapped: cover property (rd_q && !mapped);
endmodule : baro_seq_checker

bind baro_mode_seq baro_seq_checker #(.CONV15_CYCLES(CONV15_CYCLES)) chk (
    .clk(clk), .sys_rst(sys_rst), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .result_ready_pin(result_ready_pin));

// *** testbench/trig_host.sv ***
// Purpose: host side of the trigger pin
// Assumes: fire rises once per wanted conversion
// Notes:   pin timing is unrelated to the system clock
`timescale 1ns/10ps
module trig_host
#(
    parameter int LINK_NS = 125
)
(
    input wire logic fire,
    input wire logic result_ready_pin,
    output logic     trigger_pin
);
    initial trigger_pin = 1'b0;
    // pin driven both ways; a pending result blocks the edge
    always @(posedge fire)
        if (!result_ready_pin)
        begin
            #(LINK_NS / 2 + 7) trigger_pin = 1'b1;
            #(LINK_NS) trigger_pin = 1'b0;
        end
endmodule : trig_host

// *** testbench/baro_mode_seq_tb_top.sv ***
// Purpose: self-checking bench of the mode sequencer
// Assumes: scaled cycle counts 50, 20, 100
// Notes:   ce dropped once to hold a pending register trigger, front-end words constant
`timescale 1ns/10ps
module baro_mode_seq_tb_top;
    import baro_seq_pkg::*;
    localparam logic [7:0]  HS = 8'h09;
    localparam logic [7:0]  UL = 8'h0b;
    localparam logic [18:0] P  = 19'h4d2b7;
    localparam logic [13:0] T  = 14'h1f94;
    logic clk = 1'b0, sys_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, fire = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
    logic [1:0]  htrans = 2'b00;
    logic [2:0]  hsize = 3'b010;
    logic        hreadyout, hresp, result_ready_pin, trigger_pin;
    logic        ce = 1'b1;
    int          errors = 0, n_compared = 0;
    always #5 clk = ~clk;
    baro_mode_seq #(.OP_HISPEED(HS), .OP_ULTRALOW(UL), .CONV17_CYCLES(50),
        .CONV15_CYCLES(20), .ULP_CYCLES(100)) dut (.clk(clk),
        .sys_rst(sys_rst), .ce(ce), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .raw_pressure(P), .raw_temperature(T),
        .trigger_pin(trigger_pin), .result_ready_pin(result_ready_pin));
    trig_host host (.fire(fire), .result_ready_pin(result_ready_pin),
        .trigger_pin(trigger_pin));
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e)
        begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : cmp
    task automatic bus(input logic w, input logic [31:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        r = hrdata;
    endtask : bus
    function automatic logic [31:0] ba(input logic [7:0] i);
        return {22'h0, i, 2'b00};
    endfunction : ba
    // negedges to a rise must fall in lo..hi; sampled away from the edge
    task automatic wait_rdy(input int lo, input int hi);
        int n;
        for (n = 0; n < 400 && result_ready_pin !== 1'b1; n++)
            @(negedge clk);
        cmp({31'h0, n >= lo && n <= hi}, 32'h1);
    endtask : wait_rdy
    task automatic rd3(input logic [18:0] m);
        logic [18:0] pm;
        pm = P & m;
        bus(1'b0, ba(IDX_TEMP), 32'h0);
        cmp(r, {18'h0, T});
        bus(1'b0, ba(IDX_PRESS_HI), 32'h0);
        cmp(r, {29'h0, pm[18:16]});
        bus(1'b0, ba(IDX_PRESS_LO), 32'h0);
        cmp(r, {16'h0, pm[15:0]});
        repeat (3) @(posedge clk);
        cmp({31'h0, result_ready_pin}, 32'h0);
    endtask : rd3
    task automatic t_reset;
        bus(1'b0, ba(IDX_OPERATION), 32'h0);
        cmp(r, {24'h0, RST_OPERATION});
        bus(1'b0, 32'h0, 32'h0);
        cmp(r, 32'h0);
        bus(1'b0, 32'h3fc, 32'h0);
        cmp(r, 32'h0);
    endtask : t_reset
    task automatic t_trig_pin;
        fire <= 1'b1;
        wait_rdy(50, 70);
        fire <= 1'b0;
        rd3(MASK_RES17);
    endtask : t_trig_pin
    // ce low for ten edges must push the result back by ten cycles
    task automatic t_trig_reg15;
        bus(1'b1, ba(IDX_ADDPTR), {24'h0, IDX_IND_CFG});
        bus(1'b1, ba(IDX_DATAWR), {24'h0, CFG_RES15});
        bus(1'b1, ba(IDX_OPERATION), {24'h0, OP_TRIGGERED});
        ce <= 1'b0;
        repeat (10) @(posedge clk);
        ce <= 1'b1;
        wait_rdy(18, 24);
        rd3(MASK_RES15);
    endtask : t_trig_reg15
    task automatic t_cancel;
        bus(1'b1, ba(IDX_OPERATION), {24'h0, OP_STANDBY});
        bus(1'b0, ba(IDX_OPERATION_STATUS_REG), 32'h0);
        cmp(r, 32'h0);
        repeat (120) @(posedge clk);
        cmp({31'h0, result_ready_pin}, 32'h0);
    endtask : t_cancel
    // first result after one conversion, then one per refresh period
    task automatic t_modes;
        logic [7:0]  op[3] = '{OP_HIRES, HS, UL};
        logic [18:0] mk[3] = '{MASK_RES17, MASK_RES15, MASK_RES15};
        int          per[3] = '{50, 20, 100};
        int          cv[3] = '{50, 20, 20};
        for (int i = 0; i < 3; i++)
        begin
            bus(1'b1, ba(IDX_OPERATION), {24'h0, op[i]});
            bus(1'b0, ba(IDX_OPERATION_STATUS_REG), 32'h0);
            cmp(r, 32'h1);
            wait_rdy(cv[i] - 6, cv[i] + 4);
            rd3(mk[i]);
            wait_rdy(per[i] - 24, per[i]);
            rd3(mk[i]);
            t_cancel();
        end
    endtask : t_modes
    task automatic finish_test;
        if (errors == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : finish_test
    initial
    begin
        #100us;
        errors++;
        finish_test();
    end
    initial
    begin
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        t_reset();
        t_trig_pin();
        t_trig_reg15();
        t_cancel();
        t_modes();
        finish_test();
    end
endmodule : baro_mode_seq_tb_top
